/* File: touch_state_pkg.sv */
// constants shared by the touch sensor state control block
package touch_state_pkg;
  localparam int NUM_SENSORS = 8;
  localparam int CLK_HZ      = 25_000_000;
  // time base: one tick every 20 ms drives auto reset and led on-time
  localparam int TICK_MS     = 20;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int RESET_SHORT_S = 5;
  localparam int RESET_LONG_S  = 20;
  localparam logic [9:0] RESET_SHORT_TICKS =
    10'(RESET_SHORT_S * 1000 / TICK_MS);
  localparam logic [9:0] RESET_LONG_TICKS =
    10'(RESET_LONG_S * 1000 / TICK_MS);
  localparam logic [6:0] LED_TIME_MAX = 7'h64;
  // attention pulse width and least spacing (one refresh interval)
  localparam int ATTN_PULSE_US  = 10;
  localparam int ATTN_PULSE_CYCLES = CLK_HZ / 1_000_000 * ATTN_PULSE_US;
  localparam int REFRESH_MS     = 100;
  localparam int REFRESH_CYCLES = CLK_HZ / 1000 * REFRESH_MS;
  // register word addresses
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_KIND     = 8'h01;
  localparam logic [7:0] ADDR_SENS     = 8'h02;
  localparam logic [7:0] ADDR_OUTMODE  = 8'h03;
  localparam logic [7:0] ADDR_HOST_OUT = 8'h04;
  localparam logic [7:0] ADDR_LED      = 8'h05;
  localparam logic [7:0] ADDR_OVERRIDE = 8'h06;
  localparam logic [7:0] ADDR_STATUS   = 8'h07;
  localparam logic [7:0] ADDR_LATCH    = 8'h08;
  localparam logic [7:0] ADDR_NOISE    = 8'h09;
  localparam logic [7:0] ADDR_CFG_THR  = 8'h0A;
  // control register bits
  localparam int CTRL_AUTO_THR   = 0;
  localparam int CTRL_NOISE_IMM  = 1;
  localparam int CTRL_AUTO_RESET = 2;
  localparam int CTRL_PROX_LONG  = 3;
  localparam int CTRL_BTN_LONG   = 4;
  localparam logic [4:0] CTRL_RESET = 5'h01;
  // sensor kind codes, two bits per sensor
  localparam logic [1:0] KIND_BUTTON = 2'h0;
  localparam logic [1:0] KIND_SLIDER = 2'h1;
  localparam logic [1:0] KIND_PROX   = 2'h2;
  localparam logic [1:0] KIND_GUARD  = 2'h3;
  localparam logic [7:0] CFG_THR_RESET = 8'h40;
  localparam logic [8:0] AUTO_THR_MARGIN = 9'h010;
endpackage : touch_state_pkg

/* File: sensor_channel.sv */
// one sensor: auto reset, toggle, led on-time and output pin state
`timescale 1ns/1ns
module sensor_channel (
  input  wire logic       clk_sys_in,
  input  wire logic       rst_in,
  input  wire logic       active_in,
  input  wire logic       tick_in,
  input  wire logic       auto_reset_en_in,
  input  wire logic       long_period_in,
  input  wire logic       exempt_in,
  input  wire logic       toggle_en_in,
  input  wire logic       led_en_in,
  input  wire logic [6:0] led_time_in,
  input  wire logic       host_ctrl_in,
  input  wire logic       host_level_in,
  output logic            reported_out,
  output logic            reload_out,
  output logic            pin_out
);
  typedef struct packed {
    logic       reported;
    logic       stuck;
    logic [9:0] timer;
    logic [6:0] led;
    logic       toggle;
    logic       reload;
    logic       pin;
  } chan_state_type;

  chan_state_type s;
  chan_state_type next_s;
  logic [9:0]     limit;

  always_comb begin
    next_s = s;
    next_s.reload = 1'b0;
    limit = long_period_in ? touch_state_pkg::RESET_LONG_TICKS
                           : touch_state_pkg::RESET_SHORT_TICKS; // RL11
    if (!active_in || !auto_reset_en_in || exempt_in) begin
      next_s.timer = 10'h000; // RL19
      next_s.stuck = active_in && s.stuck;
    end else if (!s.stuck && tick_in) begin
      if (s.timer == limit - 10'h001) begin
        next_s.stuck  = 1'b1; // RL9
        next_s.timer  = 10'h000; // RL19
        next_s.reload = 1'b1; // RL10
      end else begin
        next_s.timer = s.timer + 10'h001;
      end
    end
    next_s.reported = active_in && !next_s.stuck; // RL9
    if (next_s.reported && !s.reported) begin
      next_s.toggle = ~s.toggle; // RL16
    end
    // led hold is not granted when auto reset turned the sensor off
    if (next_s.reported || next_s.stuck) begin
      next_s.led = 7'h00;
    end else if (s.reported && led_en_in) begin
      next_s.led = led_time_in; // RL17
    end else if (tick_in && s.led != 7'h00) begin
      next_s.led = s.led - 7'h01; // RL17
    end
    if (host_ctrl_in) begin
      next_s.pin = host_level_in; // RL18
    end else if (toggle_en_in) begin
      next_s.pin = next_s.toggle; // RL16
    end else begin
      next_s.pin = next_s.reported || next_s.led != 7'h00; // RL17
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign reported_out = s.reported;
  assign reload_out   = s.reload;
  assign pin_out      = s.pin;

  chk_reset_off: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    reload_out |-> !reported_out) else $error("reload with sensor on"); // RL9
  chk_guard_exempt: assert property (@(posedge clk_sys_in)
    disable iff (rst_in) exempt_in |=> !reload_out)
    else $error("guard sensor auto reset"); // RL13
  chk_timer_restart: assert property (@(posedge clk_sys_in)
    disable iff (rst_in) !active_in |=> s.timer == 10'h000)
    else $error("timer kept while inactive"); // RL19
  chk_toggle_flip: assert property (@(posedge clk_sys_in)
    disable iff (rst_in) $rose(reported_out) && $past(toggle_en_in)
    && $past(!host_ctrl_in) |-> pin_out != $past(pin_out))
    else $error("toggle did not invert"); // RL16
  chk_host_pin: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    host_ctrl_in |=> pin_out == $past(host_level_in))
    else $error("host level not applied"); // RL18
endmodule : sensor_channel

/* File: attention_pulse_gen.sv */
// active-low attention pulse with a least spacing between pulses
`timescale 1ns/1ns
module attention_pulse_gen #(
  parameter int PULSE_CYCLES = 250,
  parameter int GAP_CYCLES   = 2_500_000
) (
  input  wire logic clk_sys_in,
  input  wire logic rst_in,
  input  wire logic event_in,
  output logic      attention_n_out,
  output logic      attention_oe_out
);
  typedef struct packed {
    logic        pending;
    logic [21:0] pulse;
    logic [21:0] gap;
    logic        level_n;
  } attn_state_type;

  attn_state_type s;
  attn_state_type next_s;
  logic [21:0]    low_len;

  always_comb begin
    next_s = s;
    if (s.pulse != 22'h00_0000) begin
      next_s.pulse = s.pulse - 22'h00_0001;
    end
    if (s.gap != 22'h00_0000) begin
      next_s.gap = s.gap - 22'h00_0001;
    end
    if (s.pending && s.gap == 22'h00_0000) begin
      next_s.pending = 1'b0;
      next_s.pulse   = 22'(PULSE_CYCLES); // RL20
      next_s.gap     = 22'(GAP_CYCLES); // RL20
    end
    // a change seen while a pulse starts is held, not lost
    if (event_in) begin
      next_s.pending = 1'b1; // RL15
    end
    next_s.level_n = next_s.pulse == 22'h00_0000; // RL20
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      s <= '{pending: 1'b0, pulse: 22'h00_0000, gap: 22'h00_0000,
             level_n: 1'b1};
      low_len <= 22'h00_0000;
    end else begin
      s <= next_s;
      low_len <= s.level_n ? 22'h00_0000 : low_len + 22'h00_0001;
    end
  end

  assign attention_n_out  = s.level_n;
  assign attention_oe_out = !s.level_n;

  chk_pulse_len: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    $rose(attention_n_out) |-> low_len == 22'(PULSE_CYCLES))
    else $error("attention pulse width wrong"); // RL20
  chk_pulse_space: assert property (@(posedge clk_sys_in)
    disable iff (rst_in)
    $fell(attention_n_out) |-> s.gap == 22'(GAP_CYCLES))
    else $error("attention spacing not loaded"); // RL20
endmodule : attention_pulse_gen

/* File: touch_sensor_state_control.sv */
// touch sensor state control: thresholds, auto reset, status, outputs
//
// Operation
// RL1 - auto thresholds for buttons follow measured noise while running
// RL2 - host-writable control bit enables automatic thresholding
// RL3 - auto thresholds apply to buttons only; others keep configured value
// RL4 - noise immunity algorithm enabled forces auto thresholding off
// RL5 - host-written threshold values override calculated thresholds
// RL6 - sensitivity sets least capacitance change flipping sensor state
// RL7 - each button and slider has its own sensitivity selection
// RL8 - sensitivity is two bits: 0.1, 0.2, 0.3 or 0.4 pF
// RL9 - sensor active for the auto reset period is reported off
// RL10 - auto reset reloads the sensor baseline from its raw count
// RL11 - auto reset period selectable as 5 or 20 seconds
// RL12 - one period setting for proximity, one for buttons and sliders
// RL13 - guard sensor never undergoes auto reset
// RL14 - latched activation persists until host reads it
// RL15 - any sensor status change raises the host interrupt
// RL16 - toggle mode inverts the output on each new activation
// RL17 - led on-time holds the output on after release
// RL18 - host-controlled outputs follow the level written by the host
// RL19 - auto reset timer counts only while active, restarts otherwise
// RL20 - interrupt is an active-low pulse, spaced by one refresh interval
//
// The address-and-strobe port and the register addresses were decided locally.
`timescale 1ns/1ns
module touch_sensor_state_control #(
  parameter int TICK_CYCLES    = touch_state_pkg::TICK_CYCLES,
  parameter int REFRESH_CYCLES = touch_state_pkg::REFRESH_CYCLES
) (
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [15:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic      [15:0] reg_rdata_out,
  input  wire logic [7:0]  sense_active_in,
  input  wire logic [7:0]  noise_level_in,
  output logic      [63:0] threshold_out,
  output logic      [15:0] sensitivity_out,
  output logic      [7:0]  baseline_reload_out,
  output logic      [7:0]  general_output_pin_out,
  output logic             host_attention_pulse_n_out,
  output logic             host_attention_pulse_oe_out
);
  localparam int N = touch_state_pkg::NUM_SENSORS;

  typedef struct packed {
    logic [4:0]  ctrl;
    logic [15:0] kind;
    logic [15:0] sens;
    logic [7:0]  toggle_en;
    logic [7:0]  host_ctrl;
    logic [7:0]  host_out;
    logic [6:0]  led_time;
    logic [7:0]  led_en;
    logic [7:0]  ovr_val;
    logic [7:0]  ovr_en;
    logic [7:0]  cfg_thr;
    logic [7:0]  latch;
    logic [7:0]  prev_status;
    logic        change;
    logic [63:0] thr;
    logic [15:0] rdata;
    logic [18:0] tick_cnt;
    logic        tick;
  } top_state_type;

  top_state_type s;
  top_state_type next_s;
  logic [7:0]    status;
  logic [7:0]    reload;
  logic [7:0]    pins;
  logic [7:0]    is_button;
  logic [7:0]    is_prox;
  logic [7:0]    is_guard;
  logic          auto_active;
  logic [8:0]    auto_sum;
  logic [7:0]    auto_thr;

  ////////////////////////////////////////////////////////////////////////
  // per-sensor channels

  generate
    for (genvar i = 0; i < N; i++) begin : g_chan
      assign is_button[i] = s.kind[2*i +: 2] == touch_state_pkg::KIND_BUTTON;
      assign is_prox[i]   = s.kind[2*i +: 2] == touch_state_pkg::KIND_PROX;
      assign is_guard[i]  = s.kind[2*i +: 2] == touch_state_pkg::KIND_GUARD;
      sensor_channel u_chan (
        .clk_sys_in       (clk_sys_in),
        .rst_in           (rst_in),
        .active_in        (sense_active_in[i]),
        .tick_in          (s.tick),
        .auto_reset_en_in (s.ctrl[touch_state_pkg::CTRL_AUTO_RESET]),
        .long_period_in   (is_prox[i] ?
                           s.ctrl[touch_state_pkg::CTRL_PROX_LONG] :
                           s.ctrl[touch_state_pkg::CTRL_BTN_LONG]), // RL12
        .exempt_in        (is_guard[i]), // RL13
        .toggle_en_in     (s.toggle_en[i]),
        .led_en_in        (s.led_en[i]),
        .led_time_in      (s.led_time),
        .host_ctrl_in     (s.host_ctrl[i]),
        .host_level_in    (s.host_out[i]),
        .reported_out     (status[i]),
        .reload_out       (reload[i]),
        .pin_out          (pins[i])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // automatic threshold

  // noise immunity and auto threshold cannot run together
  assign auto_active = s.ctrl[touch_state_pkg::CTRL_AUTO_THR] &&
                       !s.ctrl[touch_state_pkg::CTRL_NOISE_IMM]; // RL4
  // threshold is one and a half times the noise plus a margin
  assign auto_sum = {1'b0, noise_level_in} + {2'b00, noise_level_in[7:1]}
                  + touch_state_pkg::AUTO_THR_MARGIN; // RL1
  assign auto_thr = auto_sum[8] ? 8'hFF : auto_sum[7:0];

  ////////////////////////////////////////////////////////////////////////
  // register file and state update

  always_comb begin
    next_s = s;
    next_s.rdata = 16'h0000;
    // time base
    next_s.tick = 1'b0;
    if (s.tick_cnt == 19'(TICK_CYCLES - 1)) begin
      next_s.tick_cnt = 19'h0_0000;
      next_s.tick     = 1'b1;
    end else begin
      next_s.tick_cnt = s.tick_cnt + 19'h0_0001;
    end
    // writes
    if (reg_wr_in) begin
      if (reg_addr_in == touch_state_pkg::ADDR_CTRL) begin
        next_s.ctrl = reg_wdata_in[4:0]; // RL2
      end else if (reg_addr_in == touch_state_pkg::ADDR_KIND) begin
        next_s.kind = reg_wdata_in;
      end else if (reg_addr_in == touch_state_pkg::ADDR_SENS) begin
        next_s.sens = reg_wdata_in; // RL7
      end else if (reg_addr_in == touch_state_pkg::ADDR_OUTMODE) begin
        next_s.toggle_en = reg_wdata_in[7:0];
        next_s.host_ctrl = reg_wdata_in[15:8];
      end else if (reg_addr_in == touch_state_pkg::ADDR_HOST_OUT) begin
        next_s.host_out = reg_wdata_in[7:0]; // RL18
      end else if (reg_addr_in == touch_state_pkg::ADDR_LED) begin
        next_s.led_time = reg_wdata_in[6:0] > touch_state_pkg::LED_TIME_MAX
                        ? touch_state_pkg::LED_TIME_MAX : reg_wdata_in[6:0];
        next_s.led_en   = reg_wdata_in[15:8];
      end else if (reg_addr_in == touch_state_pkg::ADDR_OVERRIDE) begin
        next_s.ovr_val = reg_wdata_in[7:0]; // RL5
        next_s.ovr_en  = reg_wdata_in[15:8];
      end else if (reg_addr_in == touch_state_pkg::ADDR_CFG_THR) begin
        next_s.cfg_thr = reg_wdata_in[7:0];
      end
    end
    // reads: data stands in the following cycle only
    if (reg_rd_in) begin
      if (reg_addr_in == touch_state_pkg::ADDR_CTRL) begin
        next_s.rdata = {11'h000, s.ctrl};
      end else if (reg_addr_in == touch_state_pkg::ADDR_KIND) begin
        next_s.rdata = s.kind;
      end else if (reg_addr_in == touch_state_pkg::ADDR_SENS) begin
        next_s.rdata = s.sens;
      end else if (reg_addr_in == touch_state_pkg::ADDR_OUTMODE) begin
        next_s.rdata = {s.host_ctrl, s.toggle_en};
      end else if (reg_addr_in == touch_state_pkg::ADDR_HOST_OUT) begin
        next_s.rdata = {8'h00, s.host_out};
      end else if (reg_addr_in == touch_state_pkg::ADDR_LED) begin
        next_s.rdata = {s.led_en, 1'b0, s.led_time};
      end else if (reg_addr_in == touch_state_pkg::ADDR_OVERRIDE) begin
        next_s.rdata = {s.ovr_en, s.ovr_val};
      end else if (reg_addr_in == touch_state_pkg::ADDR_STATUS) begin
        next_s.rdata = {8'h00, s.prev_status};
      end else if (reg_addr_in == touch_state_pkg::ADDR_LATCH) begin
        next_s.rdata = {8'h00, s.latch}; // RL14
      end else if (reg_addr_in == touch_state_pkg::ADDR_NOISE) begin
        next_s.rdata = {8'h00, noise_level_in};
      end else if (reg_addr_in == touch_state_pkg::ADDR_CFG_THR) begin
        next_s.rdata = {8'h00, s.cfg_thr};
      end
    end
    // latch clears on read, but a new activation in that cycle wins
    if (reg_rd_in && reg_addr_in == touch_state_pkg::ADDR_LATCH) begin
      next_s.latch = 8'h00; // RL14
    end
    next_s.latch       = next_s.latch | (status & ~s.prev_status); // RL14
    next_s.prev_status = status;
    next_s.change      = status != s.prev_status; // RL15
    // thresholds per sensor
    for (int i = 0; i < N; i++) begin
      if (s.ovr_en[i]) begin
        next_s.thr[8*i +: 8] = s.ovr_val; // RL5
      end else if (auto_active && is_button[i]) begin
        next_s.thr[8*i +: 8] = auto_thr; // RL1 RL3
      end else begin
        next_s.thr[8*i +: 8] = s.cfg_thr; // RL3
      end
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      s         <= '0;
      s.ctrl    <= touch_state_pkg::CTRL_RESET;
      s.cfg_thr <= touch_state_pkg::CFG_THR_RESET;
      s.thr     <= {N{touch_state_pkg::CFG_THR_RESET}};
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  attention_pulse_gen #(
    .PULSE_CYCLES (touch_state_pkg::ATTN_PULSE_CYCLES),
    .GAP_CYCLES   (REFRESH_CYCLES)
  ) u_attn (
    .clk_sys_in       (clk_sys_in),
    .rst_in           (rst_in),
    .event_in         (s.change), // RL15
    .attention_n_out  (host_attention_pulse_n_out),
    .attention_oe_out (host_attention_pulse_oe_out)
  );

  assign reg_rdata_out          = s.rdata;
  assign threshold_out          = s.thr;
  assign sensitivity_out        = s.sens; // RL6 RL8
  assign baseline_reload_out    = reload; // RL10
  assign general_output_pin_out = pins;

  ////////////////////////////////////////////////////////////////////////
  // checks

  sequence latch_set_s;
    s.latch[0] && !(reg_rd_in && reg_addr_in == touch_state_pkg::ADDR_LATCH);
  endsequence

  chk_latch_hold: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    latch_set_s |=> s.latch[0]) else $error("latched bit lost"); // RL14
  chk_noise_off: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    s.ctrl[touch_state_pkg::CTRL_NOISE_IMM] && is_button[0] && !s.ovr_en[0]
    |=> threshold_out[7:0] == $past(s.cfg_thr))
    else $error("auto threshold under noise immunity"); // RL4
  chk_override: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    s.ovr_en[1] |=> threshold_out[15:8] == $past(s.ovr_val))
    else $error("override not applied"); // RL5
  chk_change_irq: assert property (@(posedge clk_sys_in)
    disable iff (rst_in) status != s.prev_status |=> s.change)
    else $error("status change not flagged"); // RL15
endmodule : touch_sensor_state_control

/* File: touch_host_model.sv */
// host processor model: register bus master for the touch block
`timescale 1ns/1ns
module touch_host_model (
  input  wire logic        clk_sys_in,
  output logic      [7:0]  reg_addr_out,
  output logic      [15:0] reg_wdata_out,
  output logic             reg_wr_out,
  output logic             reg_rd_out
);
  initial begin
    reg_addr_out  = 8'h00;
    reg_wdata_out = 16'h0000;
    reg_wr_out    = 1'b0;
    reg_rd_out    = 1'b0;
  end
  ////////////////////////////////////////////////
  // one-cycle write; host-driven output levels go out this way
  task automatic wr(input logic [7:0] addr, input logic [15:0] data);
    @(posedge clk_sys_in);
    reg_addr_out  <= addr;
    reg_wdata_out <= data;
    reg_wr_out    <= 1'b1;
    @(posedge clk_sys_in);
    reg_wr_out    <= 1'b0;
    // released bus shows a changed pattern, not the old value
    reg_addr_out  <= ~addr;
    reg_wdata_out <= ~data;
  endtask : wr
  task automatic rd(input logic [7:0] addr);
    @(posedge clk_sys_in);
    reg_addr_out <= addr;
    reg_rd_out   <= 1'b1;
    @(posedge clk_sys_in);
    reg_rd_out   <= 1'b0;
    reg_addr_out <= ~addr;
  endtask : rd
endmodule : touch_host_model

/* File: tb_top.sv */
// self-checking bench for the touch sensor state control block
`timescale 1ns/1ns
`define CHK(got, exp) \
  begin \
    n_checks++; \
    if ((got) !== (exp)) begin \
      fail_count++; \
      $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
  end
module tb_top;
  localparam int TICKS = 10;
  localparam int REFR  = 300;
  localparam int SHORT = int'(touch_state_pkg::RESET_SHORT_TICKS) * TICKS;
  localparam int LONG  = int'(touch_state_pkg::RESET_LONG_TICKS) * TICKS;
  logic        clk_sys_in;
  logic        rst_in;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic [7:0]  sense;
  logic [7:0]  noise;
  logic [63:0] thr;
  logic [15:0] sens;
  logic [7:0]  reload;
  logic [7:0]  pin;
  logic        attn_n;
  logic        attn_oe;
  logic [15:0] exp_q[$];
  logic [15:0] rv;
  logic [15:0] rv_exp;
  logic        rd_seen = 1'b0;
  logic [7:0]  cfg;
  logic [7:0]  ov;
  int          fail_count;
  int          n_checks;
  int          cyc;
  int          low_len;
  int          last_fall;
  int          n_pulse;
  int          t0;
  int          tcount;
  integer      seed;

  touch_host_model i_touch_host_model (
    .clk_sys_in    (clk_sys_in),
    .reg_addr_out  (reg_addr),
    .reg_wdata_out (reg_wdata),
    .reg_wr_out    (reg_wr),
    .reg_rd_out    (reg_rd)
  );
  touch_sensor_state_control #(
    .TICK_CYCLES    (TICKS),
    .REFRESH_CYCLES (REFR)
  ) i_touch_sensor_state_control (
    .clk_sys_in                  (clk_sys_in),
    .rst_in                      (rst_in),
    .reg_addr_in                 (reg_addr),
    .reg_wdata_in                (reg_wdata),
    .reg_wr_in                   (reg_wr),
    .reg_rd_in                   (reg_rd),
    .reg_rdata_out               (reg_rdata),
    .sense_active_in             (sense),
    .noise_level_in              (noise),
    .threshold_out               (thr),
    .sensitivity_out             (sens),
    .baseline_reload_out         (reload),
    .general_output_pin_out      (pin),
    .host_attention_pulse_n_out  (attn_n),
    .host_attention_pulse_oe_out (attn_oe)
  );
  initial begin
    clk_sys_in = 1'b0;
    forever #20 clk_sys_in = ~clk_sys_in;
  end
  ////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  task automatic mid(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask : mid
  task automatic set_in(input logic [7:0] s, input logic [7:0] n);
    @(posedge clk_sys_in);
    sense <= s;
    noise <= n;
  endtask : set_in
  task automatic rd_chk(input logic [7:0] addr, input logic [15:0] e);
    exp_q.push_back(e);
    i_touch_host_model.rd(addr);
  endtask : rd_chk
  function automatic logic [7:0] auto_thr(input logic [7:0] n);
    logic [9:0] s;
    s = {2'b00, n} + {3'b000, n[7:1]}
      + 10'(touch_state_pkg::AUTO_THR_MARGIN);
    return (s > 10'h0ff) ? 8'hff : s[7:0];
  endfunction : auto_thr
  // kinds: 0 button, 1 slider, 2 proximity, 3 guard, 4..7 button
  task automatic thr_check(input logic auto_on, input logic [7:0] ov_en);
    logic [7:0] e;
    for (int i = 0; i < 8; i++) begin
      e = (auto_on && !(i inside {1, 2, 3})) ? auto_thr(noise) : cfg;
      if (ov_en[i])
        e = ov;
      `CHK(thr[8*i +: 8], e)
    end
  endtask : thr_check
  ////////////////////////////////////////////////
  always @(posedge clk_sys_in) rd_seen <= reg_rd;
  // read data stand one cycle only, zero otherwise
  always @(negedge clk_sys_in) begin
    if (rd_seen) begin
      rv_exp = exp_q.pop_front();
      `CHK(reg_rdata, rv_exp)
    end else
      `CHK(reg_rdata, 16'h0000)
  end
  always @(negedge clk_sys_in) begin
    cyc++;
    if (!rst_in) begin
      `CHK(attn_oe, ~attn_n)
      `CHK(reload[3], 1'b0)
      if (attn_n === 1'b0) begin
        if (low_len == 0 && n_pulse > 0)
          `CHK(1'(cyc - last_fall >= REFR), 1'b1)
        if (low_len == 0) begin
          last_fall = cyc;
          n_pulse++;
        end
        low_len++;
      end else if (low_len != 0) begin
        `CHK(low_len, touch_state_pkg::ATTN_PULSE_CYCLES)
        low_len = 0;
      end
    end
  end
  always @(posedge clk_sys_in) begin
    tcount++;
    if (tcount == 40000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  ////////////////////////////////////////////////
  initial begin
    seed   = 32'h5699;
    rst_in = 1'b1;
    sense  = 8'h00;
    noise  = 8'h00;
    mid(4);
    `CHK(thr, {8{touch_state_pkg::CFG_THR_RESET}})
    @(posedge clk_sys_in);
    rst_in <= 1'b0;
    rd_chk(touch_state_pkg::ADDR_CTRL, 16'h0001);
    rd_chk(touch_state_pkg::ADDR_CFG_THR, 16'h0040);
    rd_chk(8'h3c, 16'h0000);
    cfg = 8'($random(seed));
    ov  = 8'($random(seed));
    i_touch_host_model.wr(touch_state_pkg::ADDR_KIND, 16'h00e4);
    i_touch_host_model.wr(touch_state_pkg::ADDR_CFG_THR, {8'h00, cfg});
    set_in(8'h00, 8'($random(seed)));
    mid(3);
    thr_check(1'b1, 8'h00);
    set_in(8'h00, 8'hf0);
    mid(3);
    thr_check(1'b1, 8'h00);
    i_touch_host_model.wr(touch_state_pkg::ADDR_OVERRIDE, {8'h10, ov});
    mid(3);
    thr_check(1'b1, 8'h10);
    i_touch_host_model.wr(touch_state_pkg::ADDR_CTRL, 16'h0003);
    mid(3);
    thr_check(1'b0, 8'h10);
    i_touch_host_model.wr(touch_state_pkg::ADDR_CTRL, 16'h0000);
    i_touch_host_model.wr(touch_state_pkg::ADDR_OVERRIDE, 16'h0000);
    mid(3);
    thr_check(1'b0, 8'h00);
    for (int k = 0; k < 2; k++) begin
      rv = (k == 0) ? 16'he4e4 : 16'($random(seed));
      i_touch_host_model.wr(touch_state_pkg::ADDR_SENS, rv);
      mid(2);
      `CHK(sens, rv)
      rd_chk(touch_state_pkg::ADDR_SENS, rv);
    end
    set_in(8'h02, 8'h20);
    t0 = cyc;
    while (attn_n !== 1'b0 && cyc - t0 < 10)
      mid(1);
    `CHK(attn_n, 1'b0)
    `CHK(pin[1], 1'b1)
    set_in(8'h00, 8'h20);
    mid(3);
    rd_chk(touch_state_pkg::ADDR_STATUS, 16'h0000);
    rd_chk(touch_state_pkg::ADDR_LATCH, 16'h0002);
    rd_chk(touch_state_pkg::ADDR_LATCH, 16'h0000);
    i_touch_host_model.wr(touch_state_pkg::ADDR_OUTMODE, 16'h0004);
    for (int k = 0; k < 4; k++) begin
      set_in((k % 2 == 0) ? 8'h04 : 8'h00, 8'h20);
      mid(3);
      `CHK(pin[2], 1'(k < 2))
    end
    // host level must win over an active sensor
    i_touch_host_model.wr(touch_state_pkg::ADDR_OUTMODE, 16'h2000);
    set_in(8'h20, 8'h20);
    for (int k = 0; k < 2; k++) begin
      rv = {8'h00, 2'($random(seed)), 1'(k), 5'($random(seed))};
      i_touch_host_model.wr(touch_state_pkg::ADDR_HOST_OUT, rv);
      mid(3);
      `CHK(pin[5], rv[5])
    end
    i_touch_host_model.wr(touch_state_pkg::ADDR_OUTMODE, 16'h0000);
    i_touch_host_model.wr(touch_state_pkg::ADDR_LED, 16'h4003);
    set_in(8'h40, 8'h20);
    mid(3);
    set_in(8'h00, 8'h20);
    mid(12);
    `CHK(pin[6], 1'b1)
    mid(45);
    `CHK(pin[6], 1'b0)
    // a short gap in activation must restart the stuck timer
    i_touch_host_model.wr(touch_state_pkg::ADDR_CTRL, 16'h000d);
    set_in(8'h01, 8'h20);
    mid(SHORT - 500);
    set_in(8'h00, 8'h20);
    mid(20);
    set_in(8'h0d, 8'h20);
    t0 = cyc;
    while (reload[0] !== 1'b1 && cyc - t0 < SHORT + 100)
      mid(1);
    `CHK(1'(cyc - t0 >= SHORT - 30 && cyc - t0 <= SHORT + 30), 1'b1)
    mid(1);
    `CHK(reload[0], 1'b0)
    `CHK(pin[0], 1'b0)
    rd_chk(touch_state_pkg::ADDR_STATUS, 16'h000c);
    while (reload[2] !== 1'b1 && cyc - t0 < LONG + 100)
      mid(1);
    `CHK(1'(cyc - t0 >= LONG - 30 && cyc - t0 <= LONG + 30), 1'b1)
    mid(700);
    `CHK(1'(n_pulse >= 3), 1'b1)
    tally_and_finish();
  end
endmodule : tb_top
